// file: logic/dmap_defs.svh
// Address map, field positions and latency constants of the data-memory access unit.
`ifndef DMAP_DEFS_SVH
`define DMAP_DEFS_SVH

`define DMAP_GPIO_LAST      16'h000F
`define DMAP_GPIO_COUNT     16
`define DMAP_BITIO_MASK     16'h001F
`define DMAP_SHORTIO_MASK   16'h003F
`define DMAP_IO_LAST        16'h0FFF
`define DMAP_EE_BASE        16'h1000
`define DMAP_EE_LAST        16'h17FF
`define DMAP_SRAM_BASE      16'h2000
`define DMAP_SRAM_LAST      16'h2FFF

`define DMAP_LOCK_ADDR      16'h00A0
`define DMAP_ID0_ADDR       16'h0090
`define DMAP_ID1_ADDR       16'h0091
`define DMAP_ID2_ADDR       16'h0092
`define DMAP_REV_ADDR       16'h0093
`define DMAP_CLK_LO         16'h0040
`define DMAP_CLK_HI         16'h007F
`define DMAP_EVT_LO         16'h0180
`define DMAP_EVT_HI         16'h01BF
`define DMAP_WAV_LO         16'h0980
`define DMAP_WAV_HI         16'h09BF

`define DMAP_LAT_ONE        2'h1
`define DMAP_LAT_SRAM_RD    2'h2
`define DMAP_LAT_EE_RD      2'h3
`define DMAP_LAT_BURST      2'h2
`define DMAP_LAT_WAIT_BASE  2'h2

`define DMAP_FLASH_WORD     7:1
`define DMAP_FLASH_PAGE     16:8
`define DMAP_FLASH_BOOT_MSB 16
`define DMAP_EE_BYTE        4:0
`define DMAP_EE_PAGE        10:5
`define DMAP_EE_BYTE_LAST   5'h1F
`define DMAP_ERASED         8'hFF

`define DMAP_SRAM_AW        12
`define DMAP_EE_AW          11

`endif

// file: logic/dmap_pkg.sv
// Types shared by the data-memory access unit.
package dmap_pkg;
	typedef enum logic [2:0] {
		DMAP_IDLE  = 3'b001,
		DMAP_WAIT  = 3'b010,
		DMAP_ERASE = 3'b100
	} dmap_state_t;

	typedef enum logic [2:0] {
		DMAP_OP_LOAD  = 3'h0,
		DMAP_OP_STORE = 3'h1,
		DMAP_OP_IN    = 3'h2,
		DMAP_OP_OUT   = 3'h3,
		DMAP_OP_SETB  = 3'h4,
		DMAP_OP_CLRB  = 3'h5,
		DMAP_OP_TSTB  = 3'h6
	} dmap_op_t;

	typedef enum logic [1:0] {
		DMAP_RG_NONE = 2'h0,
		DMAP_RG_IO   = 2'h1,
		DMAP_RG_EE   = 2'h2,
		DMAP_RG_SRAM = 2'h3
	} dmap_region_t;
endpackage : dmap_pkg

// file: logic/dmap_ram.sv
// Single-port byte memory with registered read data.
`timescale 1ns/100ps
`default_nettype none
module dmap_ram #(
	parameter int AW = 12
) (
	// Clock
	input  wire logic          clk,
	// Access
	input  wire logic          we,
	input  wire logic          re,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output var  logic [7:0]    rdata_ff
);
	logic [7:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (re)
		begin
			rdata_ff <= mem[addr];
		end
	end
endmodule : dmap_ram
`default_nettype wire

// file: logic/dmap_top.sv
// Data-memory access unit: I/O space, SRAM and EEPROM timing, write lock and NVM paging.
// Overview of operation
// RULE_01: Short-form I/O ops reach only 0x00-0x3F; load/store reach all I/O.
// RULE_02: Addresses 0x00-0x1F support single-cycle bit set, clear and test.
// RULE_03: Lowest 16 I/O addresses are plain bit-accessible storage registers.
// RULE_04: Every I/O register read or write completes in one cycle.
// RULE_05: SRAM write takes one cycle; SRAM read data arrives after two.
// RULE_06: EEPROM buffer load takes one cycle; single EEPROM read takes three.
// RULE_07: Burst reads deliver a new item every second cycle.
// RULE_08: Three read-only ID bytes plus a read-only revision register.
// RULE_09: While locked, writes to clock, event and waveform registers are blocked.
// RULE_10: Lock register accepts writes only during the unlock sequence.
// RULE_11: Flash pages are word-addressed, EEPROM pages byte-addressed.
// RULE_12: Flash write and erase act on whole pages; reads are byte-wide.
// RULE_13: Flash word index is Z[7:1], page number Z[16:8], 128 words per page.
// RULE_14: 256 application pages, 16 boot pages, 16-bit program counter; the code flags all 256 pages with Z[16] set as boot.
// RULE_15: EEPROM erase works on a page or a byte; reads are byte-wide.
// RULE_16: EEPROM byte index is ADDR[4:0], page number ADDR[10:5], 32 bytes per page.
// RULE_17: EEPROM holds 2048 bytes in 64 pages.
// RULE_18: Memory-mapped EEPROM starts at data address 0x1000.
// RULE_19: Locked writes are dropped silently, with no stall and no error.
// RULE_20: Storage registers return the last value written and reset to zero.
`timescale 1ns/100ps
`default_nettype none
`include "dmap_defs.svh"
module dmap_top
	import dmap_pkg::*;
#(
	parameter logic [7:0] ID_BYTE0 = 8'h5A, // Arbitrary value.
	parameter logic [7:0] ID_BYTE1 = 8'hA5, // Arbitrary value.
	parameter logic [7:0] ID_BYTE2 = 8'h3C, // Arbitrary value.
	parameter logic [7:0] REVISION = 8'h01  // Arbitrary value.
) (
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST,
	// Core request
	input  wire logic        REQ,
	input  wire logic [2:0]  REQ_OP,
	input  wire logic [15:0] REQ_ADDR,
	input  wire logic [7:0]  REQ_WDATA,
	input  wire logic [2:0]  REQ_BIT,
	input  wire logic        REQ_BURST,
	// Core answer
	output var  logic        BUSY,
	output var  logic        DONE,
	output var  logic [7:0]  RDATA,
	output var  logic        BIT_VALUE,
	// Peripheral I/O registers
	input  wire logic [7:0]  PERIPH_RDATA,
	output var  logic        PERIPH_WE,
	output var  logic [11:0] PERIPH_ADDR,
	output var  logic [7:0]  PERIPH_WDATA,
	// Protection
	input  wire logic        CCP_OPEN,
	output var  logic [2:0]  LOCK_STATE,
	// EEPROM control
	input  wire logic        EE_MAPPED,
	input  wire logic [10:0] NVM_ADDR,
	input  wire logic        EE_ERASE,
	input  wire logic        EE_ERASE_PAGE,
	output var  logic [5:0]  EE_PAGE_NUMBER,
	output var  logic [4:0]  EE_BYTE_IN_PAGE,
	// Flash paging
	input  wire logic [16:0] FLASH_Z,
	input  wire logic        FLASH_PAGE_OP,
	output var  logic [8:0]  FLASH_PAGE_NUMBER,
	output var  logic [6:0]  FLASH_WORD_IN_PAGE,
	output var  logic        FLASH_BOOT,
	output var  logic        FLASH_PAGE_STROBE
);
	function automatic dmap_region_t region_of(input logic [15:0] a, input logic mapped);
		dmap_region_t r;
		r = DMAP_RG_NONE;
		if (a <= `DMAP_IO_LAST)
			r = DMAP_RG_IO;
		else if (a >= `DMAP_EE_BASE && a <= `DMAP_EE_LAST && mapped)
			r = DMAP_RG_EE; // see RULE_18
		else if (a >= `DMAP_SRAM_BASE && a <= `DMAP_SRAM_LAST)
			r = DMAP_RG_SRAM;
		return r;
	endfunction : region_of

	function automatic logic is_locked(input logic [15:0] a, input logic [2:0] lk);
		return (lk[0] && a >= `DMAP_CLK_LO && a <= `DMAP_CLK_HI)
			|| (lk[1] && a >= `DMAP_EVT_LO && a <= `DMAP_EVT_HI)
			|| (lk[2] && a >= `DMAP_WAV_LO && a <= `DMAP_WAV_HI); // see RULE_09
	endfunction : is_locked

	dmap_state_t  state_ff;
	dmap_op_t     op;
	dmap_region_t rg;
	logic [15:0]  eff_addr;
	logic         is_wr;
	logic         is_bitop;
	logic         accept;
	logic         erase_go;
	logic [1:0]   lat;
	logic [7:0]   io_rd;
	logic [7:0]   io_bitval;
	logic [7:0]   gpio_ff [0:`DMAP_GPIO_COUNT-1];
	logic [2:0]   lock_ff;
	logic [1:0]   cnt_ff;
	logic         src_ee_ff;
	logic         prev_ee_rd_ff;
	logic [5:0]   erase_page_ff;
	logic [4:0]   erase_cnt_ff;
	logic         erase_all_ff;
	logic         sram_we;
	logic         sram_re;
	logic         ee_we;
	logic         ee_re;
	logic [10:0]  ee_addr;
	logic [7:0]   ee_wdata;
	logic [7:0]   sram_q;
	logic [7:0]   ee_q;

	assign op       = dmap_op_t'(REQ_OP);
	assign accept   = REQ && (state_ff == DMAP_IDLE);
	assign erase_go = EE_ERASE && !REQ && (state_ff == DMAP_IDLE);
	assign is_wr    = (op == DMAP_OP_STORE) || (op == DMAP_OP_OUT)
		|| (op == DMAP_OP_SETB) || (op == DMAP_OP_CLRB);
	assign is_bitop = (op == DMAP_OP_SETB) || (op == DMAP_OP_CLRB) || (op == DMAP_OP_TSTB);
	assign rg       = region_of(eff_addr, EE_MAPPED);

	// Short forms carry a narrow address field, so they cannot leave their window.
	always_comb
	begin
		if (is_bitop)
			eff_addr = REQ_ADDR & `DMAP_BITIO_MASK; // see RULE_02
		else if (op == DMAP_OP_IN || op == DMAP_OP_OUT)
			eff_addr = REQ_ADDR & `DMAP_SHORTIO_MASK; // see RULE_01
		else
			eff_addr = REQ_ADDR;
	end

	always_comb
	begin
		if (eff_addr <= `DMAP_GPIO_LAST)
			io_rd = gpio_ff[eff_addr[3:0]]; // see RULE_20
		else if (eff_addr == `DMAP_LOCK_ADDR)
			io_rd = {5'h00, lock_ff};
		else if (eff_addr == `DMAP_ID0_ADDR)
			io_rd = ID_BYTE0; // see RULE_08
		else if (eff_addr == `DMAP_ID1_ADDR)
			io_rd = ID_BYTE1;
		else if (eff_addr == `DMAP_ID2_ADDR)
			io_rd = ID_BYTE2;
		else if (eff_addr == `DMAP_REV_ADDR)
			io_rd = REVISION;
		else
			io_rd = PERIPH_RDATA;
	end

	// Bit set and clear rewrite the whole byte with one bit changed.
	always_comb
	begin
		io_bitval = io_rd;
		if (op == DMAP_OP_SETB)
			io_bitval[REQ_BIT] = 1'b1;
		else if (op == DMAP_OP_CLRB)
			io_bitval[REQ_BIT] = 1'b0;
		else if (!is_bitop)
			io_bitval = REQ_WDATA;
	end

	always_comb
	begin
		lat = `DMAP_LAT_ONE; // see RULE_04
		if (!is_wr && rg == DMAP_RG_SRAM)
			lat = `DMAP_LAT_SRAM_RD; // see RULE_05
		else if (!is_wr && rg == DMAP_RG_EE)
			lat = (REQ_BURST && prev_ee_rd_ff) ? `DMAP_LAT_BURST : `DMAP_LAT_EE_RD; // see RULE_07
	end

	assign sram_we  = accept && is_wr && rg == DMAP_RG_SRAM; // see RULE_05
	assign sram_re  = accept && !is_wr && rg == DMAP_RG_SRAM;
	assign ee_we    = (accept && is_wr && rg == DMAP_RG_EE) || (state_ff == DMAP_ERASE); // see RULE_06
	assign ee_re    = accept && !is_wr && rg == DMAP_RG_EE;
	assign ee_addr  = (state_ff == DMAP_ERASE) ? {erase_page_ff, erase_cnt_ff} : eff_addr[10:0];
	assign ee_wdata = (state_ff == DMAP_ERASE) ? `DMAP_ERASED : REQ_WDATA;

	dmap_ram #(.AW(`DMAP_SRAM_AW)) u_sram (
		.clk      (CLOCK),
		.we       (sram_we),
		.re       (sram_re),
		.addr     (eff_addr[`DMAP_SRAM_AW-1:0]),
		.wdata    (REQ_WDATA),
		.rdata_ff (sram_q)
	);

	// 2048 bytes, indexed as 64 pages of 32 bytes.
	dmap_ram #(.AW(`DMAP_EE_AW)) u_eeprom (
		.clk      (CLOCK),
		.we       (ee_we),
		.re       (ee_re),
		.addr     (ee_addr),
		.wdata    (ee_wdata),
		.rdata_ff (ee_q)
	); // see RULE_17

	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			state_ff <= DMAP_IDLE;
			cnt_ff   <= 2'h0;
		end
		else
		begin
			case (state_ff)
				DMAP_IDLE:
				begin
					if (accept && lat != `DMAP_LAT_ONE)
					begin
						state_ff <= DMAP_WAIT;
						cnt_ff   <= lat - `DMAP_LAT_WAIT_BASE;
					end
					else if (erase_go)
					begin
						state_ff <= DMAP_ERASE;
					end
				end
				DMAP_WAIT:
				begin
					if (cnt_ff == 2'h0)
						state_ff <= DMAP_IDLE;
					else
						cnt_ff <= cnt_ff - 2'h1;
				end
				DMAP_ERASE:
				begin
					if (!erase_all_ff || erase_cnt_ff == `DMAP_EE_BYTE_LAST)
						state_ff <= DMAP_IDLE;
				end
				default:
				begin
					state_ff <= DMAP_IDLE;
				end
			endcase
		end
	end

	// Erase either a single byte or the whole page that NVM_ADDR points into.
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			erase_page_ff <= 6'h00;
			erase_cnt_ff  <= 5'h00;
			erase_all_ff  <= 1'b0;
		end
		else if (erase_go)
		begin
			erase_page_ff <= NVM_ADDR[`DMAP_EE_PAGE];
			erase_cnt_ff  <= EE_ERASE_PAGE ? 5'h00 : NVM_ADDR[`DMAP_EE_BYTE]; // see RULE_15
			erase_all_ff  <= EE_ERASE_PAGE;
		end
		else if (state_ff == DMAP_ERASE)
		begin
			erase_cnt_ff <= erase_cnt_ff + 5'h01;
		end
	end

	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			DONE          <= 1'b0;
			RDATA         <= 8'h00;
			BIT_VALUE     <= 1'b0;
			src_ee_ff     <= 1'b0;
			prev_ee_rd_ff <= 1'b0;
		end
		else
		begin
			DONE <= 1'b0;
			if (accept)
			begin
				src_ee_ff     <= rg == DMAP_RG_EE;
				prev_ee_rd_ff <= !is_wr && rg == DMAP_RG_EE;
				if (lat == `DMAP_LAT_ONE)
				begin
					DONE <= 1'b1;
					if (rg == DMAP_RG_IO && !is_wr)
						RDATA <= io_rd;
					else if (!is_wr)
						RDATA <= 8'h00;
					BIT_VALUE <= io_rd[REQ_BIT]; // see RULE_02
				end
			end
			else if (state_ff == DMAP_WAIT && cnt_ff == 2'h0)
			begin
				DONE  <= 1'b1;
				RDATA <= src_ee_ff ? ee_q : sram_q;
			end
			else if (state_ff == DMAP_IDLE && !REQ)
			begin
				prev_ee_rd_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			BUSY <= 1'b0;
		end
		else
		begin
			BUSY <= (accept && lat != `DMAP_LAT_ONE) || erase_go
				|| (state_ff == DMAP_WAIT && cnt_ff != 2'h0)
				|| (state_ff == DMAP_ERASE && erase_all_ff && erase_cnt_ff != `DMAP_EE_BYTE_LAST);
		end
	end

	// Storage registers sit behind the same bit path as every low I/O address.
	genvar gi;
	generate
		for (gi = 0; gi < `DMAP_GPIO_COUNT; gi++)
		begin : g_gpio
			always_ff @(posedge CLOCK or posedge RST)
			begin
				if (RST)
					gpio_ff[gi] <= 8'h00; // see RULE_20
				else if (accept && is_wr && eff_addr == 16'(gi))
					gpio_ff[gi] <= io_bitval; // see RULE_03
			end
		end
	endgenerate

	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			lock_ff <= 3'h0;
		else if (accept && is_wr && eff_addr == `DMAP_LOCK_ADDR && CCP_OPEN)
			lock_ff <= io_bitval[2:0]; // see RULE_10
	end

	// A locked write still finishes in one cycle; the strobe is simply withheld.
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			PERIPH_WE    <= 1'b0;
			PERIPH_ADDR  <= 12'h000;
			PERIPH_WDATA <= 8'h00;
		end
		else
		begin
			PERIPH_WE <= accept && is_wr && rg == DMAP_RG_IO
				&& eff_addr > `DMAP_GPIO_LAST && eff_addr != `DMAP_LOCK_ADDR
				&& eff_addr != `DMAP_ID0_ADDR && eff_addr != `DMAP_ID1_ADDR
				&& eff_addr != `DMAP_ID2_ADDR && eff_addr != `DMAP_REV_ADDR
				&& !is_locked(eff_addr, lock_ff); // see RULE_19
			if (accept)
			begin
				PERIPH_ADDR  <= eff_addr[11:0];
				PERIPH_WDATA <= io_bitval;
			end
		end
	end

	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			LOCK_STATE        <= 3'h0;
			EE_PAGE_NUMBER    <= 6'h00;
			EE_BYTE_IN_PAGE   <= 5'h00;
			FLASH_PAGE_NUMBER <= 9'h000;
			FLASH_WORD_IN_PAGE <= 7'h00;
			FLASH_BOOT        <= 1'b0;
			FLASH_PAGE_STROBE <= 1'b0;
		end
		else
		begin
			LOCK_STATE         <= lock_ff;
			EE_PAGE_NUMBER     <= NVM_ADDR[`DMAP_EE_PAGE]; // see RULE_16
			EE_BYTE_IN_PAGE    <= NVM_ADDR[`DMAP_EE_BYTE]; // see RULE_11
			FLASH_PAGE_NUMBER  <= FLASH_Z[`DMAP_FLASH_PAGE]; // see RULE_13
			FLASH_WORD_IN_PAGE <= FLASH_Z[`DMAP_FLASH_WORD];
			FLASH_BOOT         <= FLASH_Z[`DMAP_FLASH_BOOT_MSB]; // see RULE_14
			FLASH_PAGE_STROBE  <= FLASH_PAGE_OP; // see RULE_12
		end
	end

	io_one_cycle_a: assert property (@(posedge CLOCK) disable iff (RST) // see RULE_04
		accept && rg == DMAP_RG_IO |=> DONE && !BUSY)
		else $error("I/O access did not finish in one cycle");

	sram_read_lat_a: assert property (@(posedge CLOCK) disable iff (RST) // see RULE_05
		accept && !is_wr && rg == DMAP_RG_SRAM |=> !DONE ##1 DONE)
		else $error("SRAM read latency is not two cycles");

	ee_read_lat_a: assert property (@(posedge CLOCK) disable iff (RST) // see RULE_06
		accept && !is_wr && rg == DMAP_RG_EE && !(REQ_BURST && prev_ee_rd_ff)
		|=> !DONE ##1 !DONE ##1 DONE)
		else $error("EEPROM read latency is not three cycles");

	burst_pace_a: assert property (@(posedge CLOCK) disable iff (RST) // see RULE_07
		accept && !is_wr && rg == DMAP_RG_EE && REQ_BURST && prev_ee_rd_ff
		|=> !DONE ##1 DONE)
		else $error("Burst item not delivered on second cycle");

	gpio_store_a: assert property (@(posedge CLOCK) disable iff (RST) // see RULE_20
		accept && op == DMAP_OP_STORE && REQ_ADDR <= `DMAP_GPIO_LAST
		|=> gpio_ff[$past(REQ_ADDR[3:0])] == $past(REQ_WDATA))
		else $error("Storage register did not keep written value");

	locked_drop_a: assert property (@(posedge CLOCK) disable iff (RST) // see RULE_09
		accept && is_wr && is_locked(eff_addr, lock_ff) |=> !PERIPH_WE && DONE)
		else $error("Write to locked register was not dropped");

	lock_guard_a: assert property (@(posedge CLOCK) disable iff (RST) // see RULE_10
		!(accept && is_wr && eff_addr == `DMAP_LOCK_ADDR && CCP_OPEN) |=> $stable(lock_ff))
		else $error("Lock changed outside unlock sequence");

	short_io_a: assert property (@(posedge CLOCK) disable iff (RST) // see RULE_01
		accept && op == DMAP_OP_OUT |=> PERIPH_ADDR <= `DMAP_SHORTIO_MASK)
		else $error("Short I/O form left its address window");

	flash_split_a: assert property (@(posedge CLOCK) disable iff (RST) // see RULE_13
		1'b1 |=> FLASH_PAGE_NUMBER == $past(FLASH_Z[`DMAP_FLASH_PAGE])
			&& FLASH_WORD_IN_PAGE == $past(FLASH_Z[`DMAP_FLASH_WORD]))
		else $error("Flash page split wrong");

	page_erase_a: assert property (@(posedge CLOCK) disable iff (RST) // see RULE_15
		erase_go && EE_ERASE_PAGE |=> BUSY ##31 BUSY ##1 !BUSY)
		else $error("Page erase did not span 32 cycles");
endmodule : dmap_top
`default_nettype wire

// file: tb/dmap_periph_model.sv
// Peripheral register file that answers the I/O port of the access unit.
`timescale 1ns/100ps
`default_nettype none
module dmap_periph_model (
	// Clock
	input  wire logic        clk,
	// Read side, follows the core address
	input  wire logic [15:0] req_addr,
	output var  logic [7:0]  rdata,
	// Write side
	input  wire logic        we,
	input  wire logic [11:0] waddr,
	input  wire logic [7:0]  wdata
);
	logic [7:0] mem [4096];
	// A preloaded pattern keeps untouched registers, except those whose low address byte is A5, from reading as zero.
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'(i) ^ 8'hA5;
	end
	assign rdata = mem[req_addr[11:0]];
	always @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end
endmodule : dmap_periph_model
`default_nettype wire

// file: tb/test_io_memory_access_and_nvm_paging.sv
// Self-checking bench for the data-memory access unit.
`timescale 1ns/100ps
`default_nettype none
module test_io_memory_access_and_nvm_paging
	import dmap_pkg::*;
();
	localparam logic [7:0] IDS [4] = '{8'h21, 8'h43, 8'h65, 8'h07}; // Arbitrary values.
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        req = 1'b0;
	logic [2:0]  op = 3'h0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wd = 8'h00;
	logic [2:0]  bsel = 3'h0;
	logic        burst = 1'b0;
	logic        ccp = 1'b0;
	logic        ee_map = 1'b0;
	logic [10:0] nvm = 11'h000;
	logic        ers = 1'b0;
	logic        ers_pg = 1'b0;
	logic [16:0] z = 17'h00000;
	logic        fpop = 1'b0;
	wire logic   busy, done, bitv, pwe, fboot, fstb;
	wire logic [7:0]  rdata, prd, pwd;
	wire logic [11:0] paddr;
	wire logic [2:0]  lck;
	wire logic [5:0]  ee_pg;
	wire logic [4:0]  ee_by;
	wire logic [8:0]  flash_page_number;
	wire logic [6:0]  flash_word_in_page;
	int          fail_count = 0;
	int          tests_run = 0;

	dmap_top #(.ID_BYTE0(IDS[0]), .ID_BYTE1(IDS[1]), .ID_BYTE2(IDS[2]), .REVISION(IDS[3]))
	dmap_top_i (
		.CLOCK(clock), .RST(rst), .REQ(req), .REQ_OP(op), .REQ_ADDR(addr),
		.REQ_WDATA(wd), .REQ_BIT(bsel), .REQ_BURST(burst), .BUSY(busy), .DONE(done),
		.RDATA(rdata), .BIT_VALUE(bitv), .PERIPH_RDATA(prd), .PERIPH_WE(pwe),
		.PERIPH_ADDR(paddr), .PERIPH_WDATA(pwd), .CCP_OPEN(ccp), .LOCK_STATE(lck),
		.EE_MAPPED(ee_map), .NVM_ADDR(nvm), .EE_ERASE(ers), .EE_ERASE_PAGE(ers_pg),
		.EE_PAGE_NUMBER(ee_pg), .EE_BYTE_IN_PAGE(ee_by), .FLASH_Z(z), .FLASH_PAGE_OP(fpop),
		.FLASH_PAGE_NUMBER(flash_page_number), .FLASH_WORD_IN_PAGE(flash_word_in_page), .FLASH_BOOT(fboot),
		.FLASH_PAGE_STROBE(fstb)
	);
	dmap_periph_model dmap_periph_model_i (
		.clk(clock), .req_addr(addr), .rdata(prd), .we(pwe), .waddr(paddr), .wdata(pwd)
	);

	always #5 clock = ~clock;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk

	// One core access; the request is dropped right after the edge that takes it.
	task automatic acc(input logic [2:0] o, input logic [15:0] a, input logic [7:0] d,
		input logic [2:0] b, input int lat);
		int n;
		n = 0;
		@(posedge clock);
		req <= 1'b1;
		op <= o;
		addr <= a;
		wd <= d;
		bsel <= b;
		@(posedge clock);
		req <= 1'b0;
		#1;
		n = 1;
		while (done !== 1'b1 && n < 12)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("latency", n, lat);
	endtask : acc

	task automatic t_gpio();
		for (int i = 0; i < 16; i++)
		begin
			acc(DMAP_OP_LOAD, 16'(i), 8'h00, 3'h0, 1);
			chk("gpio reset", rdata, 8'h00);
		end
		acc(DMAP_OP_STORE, 16'h000F, 8'h69, 3'h0, 1);
		chk("gpio internal", pwe, 1'b0);
		acc(DMAP_OP_LOAD, 16'h000F, 8'h00, 3'h0, 1);
		chk("gpio readback", rdata, 8'h69);
		acc(DMAP_OP_SETB, 16'hFFE3, 8'h00, 3'h5, 1);
		chk("setb old", bitv, 1'b0);
		acc(DMAP_OP_TSTB, 16'h0003, 8'h00, 3'h5, 1);
		chk("tstb", bitv, 1'b1);
		acc(DMAP_OP_CLRB, 16'h0003, 8'h00, 3'h5, 1);
		acc(DMAP_OP_LOAD, 16'h0003, 8'h00, 3'h0, 1);
		chk("clrb", rdata, 8'h00);
		acc(DMAP_OP_SETB, 16'h001A, 8'h00, 3'h6, 1);
		chk("setb periph", {pwe, paddr, pwd}, {1'b1, 12'h01A, 8'hFF});
		$display("test gpio finished");
	endtask : t_gpio

	task automatic t_io();
		acc(DMAP_OP_OUT, 16'hFFE5, 8'h3C, 3'h0, 1);
		chk("out", {pwe, paddr, pwd}, {1'b1, 12'h025, 8'h3C});
		acc(DMAP_OP_IN, 16'h0025, 8'h00, 3'h0, 1);
		chk("in", rdata, 8'h3C);
		acc(DMAP_OP_LOAD, 16'h0E30, 8'h00, 3'h0, 1);
		chk("load far io", rdata, 8'h95);
		for (int i = 0; i < 4; i++)
		begin
			acc(DMAP_OP_LOAD, 16'h0090 + 16'(i), 8'h00, 3'h0, 1);
			chk("id read", rdata, IDS[i]);
		end
		acc(DMAP_OP_STORE, 16'h0090, 8'h00, 3'h0, 1);
		chk("id write", pwe, 1'b0);
		acc(DMAP_OP_LOAD, 16'h0090, 8'h00, 3'h0, 1);
		chk("id kept", rdata, IDS[0]);
		$display("test io finished");
	endtask : t_io

	task automatic t_sram();
		acc(DMAP_OP_STORE, 16'h2FFF, 8'h5C, 3'h0, 1);
		acc(DMAP_OP_STORE, 16'h2000, 8'hC5, 3'h0, 1);
		acc(DMAP_OP_LOAD, 16'h2FFF, 8'h00, 3'h0, 2);
		chk("sram top", rdata, 8'h5C);
		acc(DMAP_OP_LOAD, 16'h2000, 8'h00, 3'h0, 2);
		chk("sram base", rdata, 8'hC5);
		$display("test sram finished");
	endtask : t_sram

	task automatic t_ee();
		int n;
		@(posedge clock);
		ee_map <= 1'b1;
		acc(DMAP_OP_STORE, 16'h1000, 8'h11, 3'h0, 1);
		acc(DMAP_OP_STORE, 16'h1001, 8'h22, 3'h0, 1);
		acc(DMAP_OP_STORE, 16'h1025, 8'h33, 3'h0, 1);
		acc(DMAP_OP_STORE, 16'h17FF, 8'h77, 3'h0, 1);
		acc(DMAP_OP_LOAD, 16'h17FF, 8'h00, 3'h0, 3);
		chk("ee last", rdata, 8'h77);
		acc(DMAP_OP_LOAD, 16'h1800, 8'h00, 3'h0, 1);
		chk("past ee", rdata, 8'h00);
		@(posedge clock);
		req <= 1'b1;
		op <= DMAP_OP_LOAD;
		addr <= 16'h1000;
		repeat (3) @(posedge clock);
		addr <= 16'h1001;
		burst <= 1'b1;
		#1;
		chk("burst first", {done, rdata}, {1'b1, 8'h11});
		@(posedge clock);
		req <= 1'b0;
		burst <= 1'b0;
		#1;
		chk("burst gap", done, 1'b0);
		@(posedge clock);
		#1;
		chk("burst second", {done, rdata}, {1'b1, 8'h22});
		@(posedge clock);
		nvm <= 11'h7FF;
		repeat (3) @(posedge clock);
		#1;
		chk("ee fields", {ee_pg, ee_by}, {6'h3F, 5'h1F});
		@(posedge clock);
		nvm <= 11'h025;
		ers <= 1'b1;
		ers_pg <= 1'b1;
		@(posedge clock);
		ers <= 1'b0;
		n = 0;
		repeat (40)
		begin
			#1;
			if (busy === 1'b1)
				n++;
			@(posedge clock);
		end
		#1;
		chk("page erase", n, 32);
		chk("ee page 1", {ee_pg, ee_by}, {6'h01, 5'h05});
		acc(DMAP_OP_LOAD, 16'h1025, 8'h00, 3'h0, 3);
		chk("erased", rdata, 8'hFF);
		acc(DMAP_OP_LOAD, 16'h1000, 8'h00, 3'h0, 3);
		chk("other page", rdata, 8'h11);
		@(posedge clock);
		nvm <= 11'h001;
		ers <= 1'b1;
		ers_pg <= 1'b0;
		@(posedge clock);
		ers <= 1'b0;
		n = 0;
		repeat (6)
		begin
			#1;
			if (busy === 1'b1)
				n++;
			@(posedge clock);
		end
		chk("byte erase", n, 1);
		acc(DMAP_OP_LOAD, 16'h1001, 8'h00, 3'h0, 3);
		chk("byte erased", rdata, 8'hFF);
		acc(DMAP_OP_LOAD, 16'h1000, 8'h00, 3'h0, 3);
		chk("byte kept", rdata, 8'h11);
		@(posedge clock);
		ee_map <= 1'b0;
		acc(DMAP_OP_LOAD, 16'h1000, 8'h00, 3'h0, 1);
		chk("unmapped", rdata, 8'h00);
		$display("test eeprom finished");
	endtask : t_ee

	task automatic t_lock();
		logic [15:0] lk [5] = '{16'h0040, 16'h007F, 16'h01BF, 16'h0980, 16'h09BF};
		acc(DMAP_OP_STORE, 16'h0040, 8'h5A, 3'h0, 1);
		chk("open write", pwe, 1'b1);
		acc(DMAP_OP_STORE, 16'h00A0, 8'h07, 3'h0, 1);
		@(posedge clock);
		#1;
		chk("lock refused", lck, 3'h0);
		@(posedge clock);
		ccp <= 1'b1;
		acc(DMAP_OP_STORE, 16'h00A0, 8'h07, 3'h0, 1);
		@(posedge clock);
		#1;
		chk("lock set", lck, 3'h7);
		@(posedge clock);
		ccp <= 1'b0;
		foreach (lk[i])
		begin
			acc(DMAP_OP_STORE, lk[i], 8'hEE, 3'h0, 1);
			chk("locked write", pwe, 1'b0);
		end
		acc(DMAP_OP_STORE, 16'h0080, 8'hEE, 3'h0, 1);
		chk("beside range", pwe, 1'b1);
		acc(DMAP_OP_LOAD, 16'h0040, 8'h00, 3'h0, 1);
		chk("locked kept", rdata, 8'h5A);
		@(posedge clock);
		ccp <= 1'b1;
		acc(DMAP_OP_STORE, 16'h00A0, 8'h00, 3'h0, 1);
		@(posedge clock);
		#1;
		chk("unlock", lck, 3'h0);
		$display("test lock finished");
	endtask : t_lock

	task automatic t_flash();
		int n;
		@(posedge clock);
		z <= 17'h12345;
		fpop <= 1'b1;
		@(posedge clock);
		fpop <= 1'b0;
		n = 0;
		repeat (4)
		begin
			#1;
			if (fstb === 1'b1)
				n++;
			@(posedge clock);
		end
		#1;
		chk("page strobe", n, 1);
		chk("boot fields", {flash_page_number, flash_word_in_page, fboot}, {9'h123, 7'h22, 1'b1});
		@(posedge clock);
		z <= 17'h0FFFE;
		repeat (3) @(posedge clock);
		#1;
		chk("app fields", {flash_page_number, flash_word_in_page, fboot}, {9'h0FF, 7'h7F, 1'b0});
		$display("test flash finished");
	endtask : t_flash

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	initial
	begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_gpio();
		t_io();
		t_sram();
		t_ee();
		t_lock();
		t_flash();
		conclude();
	end

	// The planned sequence needs well under two thousand cycles.
	initial
	begin
		#200000;
		fail_count++;
		conclude();
	end
endmodule : test_io_memory_access_and_nvm_paging
`default_nettype wire
